//--- design/tpc_defines.svh
// Constants for the PWM and carrier generator timer block
// Notes on behaviour
// - On run enable, first count clock is swallowed; output stays inactive.
// - Duty write while counting is latched; the old duty value stays in use.
// - Latched duty moves in on old-duty match, unless fewer than three clocks passed.
// - PWM cycle match clears counter, drives output active, pulses the match interrupt.
// - PWM duty match drives output inactive; no clear and no interrupt.
// - Clearing run enable forces interrupt inactive, and output pin inactive unless carrier mode has remote 0.
// - Carrier mode exists only on timer index 1, gated by gate timer interrupt.
// - Low compare sets low width, high compare high width; low not rewritten running.
// - Pin low if enable 0, high if remote 0, carrier if both 1.
// - Staged enable is read/write; active enable is read-only, loaded from staged.
// - Gate interrupt synced to count clock; staged copied at second clock after.
// - Low compare first; each match pulses interrupt, clears, inverts carrier, swaps.
// - Carrier period is N+M+2 count clocks, high level M+1.
// - Carrier mode start holds internal carrier low until first low-compare match.
// - Active enable rising starts passing carrier at next carrier rising edge.
// - Active enable dropping while carrier high keeps pin high until carrier low.
// - PWM period N+1 count clocks, active width M+1, with M below N.
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_ADDR_W 3
`define TPC_DATA_W 8
`define TPC_OFS_CTRL 3'h0
`define TPC_OFS_CMP_A 3'h1
`define TPC_OFS_CMP_B 3'h2
`define TPC_OFS_CARRIER 3'h3
`define TPC_OFS_COUNT 3'h4
`define TPC_CTRL_RUN 0
`define TPC_CTRL_MODE 1
`define TPC_CTRL_LEVEL 2
`define TPC_CAR_ACTIVE 0
`define TPC_CAR_STAGED 1
`define TPC_CAR_REMOTE 2
`define TPC_RST_BYTE 8'h00
`define TPC_DUTY_AGE_MIN 2'h3
`define TPC_XFER_CLOCKS 2'h2
`define TPC_TIMER_INDEX 1
`endif

//--- design/tpc_pkg.sv
// Types shared by the PWM and carrier generator timer block
package tpc_pkg;
   typedef enum logic {
      TPC_SEL_A = 1'b0,
      TPC_SEL_B = 1'b1
   } tpc_sel_e;
   typedef logic [7:0] tpc_byte_t;
   typedef struct packed {
      logic sync_q;
      logic [1:0] xcnt;
      logic active;
   } tpc_xfer_s;
   typedef struct packed {
      logic running;
      logic mask;
      logic carrier_mode;
      logic level_sel;
      tpc_sel_e sel;
      tpc_byte_t cnt;
      tpc_byte_t cmp_a;
      tpc_byte_t duty_act;
      tpc_byte_t duty_latch;
      logic pending;
      logic [1:0] age;
      logic pwm_out;
      logic carrier;
      logic pass;
      logic staged;
      logic remote;
      logic irq;
      logic pin;
      tpc_byte_t rdata;
   } tpc_state_s;
endpackage : tpc_pkg

//--- design/tpc_gate_xfer.sv
// Gate interrupt synchroniser and staged-to-active carrier enable transfer
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_gate_xfer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic gate_irq_i,
   input wire logic staged_i,
   output logic synced_o,
   output logic active_o
);
   tpc_pkg::tpc_xfer_s q;
   tpc_pkg::tpc_xfer_s d;

   // Sampling on the count tick makes the gate event one count clock wide
   always_comb begin
      d = q;
      if (tick_i) begin
         d.sync_q = gate_irq_i;
         if (q.xcnt == `TPC_XFER_CLOCKS) begin
            d.active = staged_i;
            d.xcnt = 2'h0;
         end else if (q.xcnt != 2'h0) begin
            d.xcnt = q.xcnt + 2'h1;
         end
         if (gate_irq_i && !q.sync_q) begin
            d.xcnt = 2'h1;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign synced_o = q.sync_q;
   assign active_o = q.active; // Only path into the active enable

   a_xfer_second: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick_i && q.xcnt == `TPC_XFER_CLOCKS) |=> (q.active == $past(staged_i)))
      else $error("active enable not loaded at second count clock");
   a_xfer_only: assert property (@(posedge clk_i) disable iff (rst_i)
      !(tick_i && q.xcnt == `TPC_XFER_CLOCKS) |=> $stable(q.active))
      else $error("active enable changed outside a transfer");
endmodule : tpc_gate_xfer

//--- design/tpc_timer.sv
// PWM and carrier generator timer with its register port
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_timer (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic CNT_TICK_I,
   input wire logic GATE_IRQ_I,
   input wire logic [`TPC_ADDR_W-1:0] ADDR_I,
   input wire logic [`TPC_DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [`TPC_DATA_W-1:0] RDATA_O,
   output logic TOUT_O,
   output logic IRQ_O
);
   tpc_pkg::tpc_state_s q;
   tpc_pkg::tpc_state_s d;
   logic active_en;
   logic synced_pulse;

   // Compare selected for the current half of the waveform
   function automatic tpc_pkg::tpc_byte_t cmp_value(input tpc_pkg::tpc_state_s s);
      cmp_value = (s.sel == tpc_pkg::TPC_SEL_A) ? s.cmp_a : s.duty_act;
   endfunction : cmp_value

   // Gate interrupt crossing and the master/slave enable pair
   tpc_gate_xfer u_xfer (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .tick_i(CNT_TICK_I),
      .gate_irq_i(GATE_IRQ_I),
      .staged_i(q.staged),
      .synced_o(synced_pulse),
      .active_o(active_en)
   );

   logic wr_ctrl;
   logic wr_cmp_a;
   logic wr_cmp_b;
   logic wr_car;
   logic match;
   assign wr_ctrl = WR_I && (ADDR_I == `TPC_OFS_CTRL);
   assign wr_cmp_a = WR_I && (ADDR_I == `TPC_OFS_CMP_A);
   assign wr_cmp_b = WR_I && (ADDR_I == `TPC_OFS_CMP_B);
   assign wr_car = WR_I && (ADDR_I == `TPC_OFS_CARRIER);
   assign match = (q.cnt == cmp_value(q));

   // Next-state logic: register writes first, then the counting engine
   always_comb begin
      d = q;
      d.rdata = `TPC_RST_BYTE;
      if (wr_ctrl) begin
         d.level_sel = WDATA_I[`TPC_CTRL_LEVEL];
         // Mode change only while stopped; carrier mode is a one-instance feature
         if (!q.running) begin
            d.carrier_mode = WDATA_I[`TPC_CTRL_MODE] && (`TPC_TIMER_INDEX == 1);
         end
         if (WDATA_I[`TPC_CTRL_RUN] && !q.running) begin
            d.running = 1'b1;
            d.mask = 1'b1;
            d.cnt = `TPC_RST_BYTE;
            d.sel = tpc_pkg::TPC_SEL_A;
            d.pwm_out = 1'b0;
            d.carrier = 1'b0;
            d.pass = 1'b0;
            d.irq = 1'b0;
         end else if (!WDATA_I[`TPC_CTRL_RUN]) begin
            d.running = 1'b0;
            d.irq = 1'b0;
            d.pwm_out = 1'b0;
            d.carrier = 1'b0;
            d.pass = 1'b0;
         end
      end
      // A running low/cycle compare is never replaced under the counter
      if (wr_cmp_a && !q.running) begin
         d.cmp_a = WDATA_I;
      end
      if (wr_cmp_b) begin
         d.duty_latch = WDATA_I;
         if (q.running) begin
            d.pending = 1'b1;
            d.age = 2'h0;
         end else begin
            d.duty_act = WDATA_I;
            d.pending = 1'b0;
         end
      end
      if (wr_car) begin
         d.staged = WDATA_I[`TPC_CAR_STAGED];
         d.remote = WDATA_I[`TPC_CAR_REMOTE];
      end
      // Count engine advances only on the selected count clock
      if (CNT_TICK_I && q.running && !(wr_ctrl && !WDATA_I[`TPC_CTRL_RUN])) begin
         d.irq = 1'b0;
         if (q.pending && q.age != `TPC_DUTY_AGE_MIN && !wr_cmp_b) begin
            d.age = q.age + 2'h1;
         end
         if (q.mask) begin
            d.mask = 1'b0;
         end else if (!match) begin
            d.cnt = q.cnt + 8'h01;
         end else if (q.carrier_mode) begin
            d.irq = 1'b1;
            d.cnt = `TPC_RST_BYTE;
            d.carrier = !q.carrier;
            d.sel = (q.sel == tpc_pkg::TPC_SEL_A) ? tpc_pkg::TPC_SEL_B : tpc_pkg::TPC_SEL_A;
         end else if (q.sel == tpc_pkg::TPC_SEL_A) begin
            d.cnt = `TPC_RST_BYTE;
            d.pwm_out = 1'b1;
            d.irq = 1'b1;
            d.sel = tpc_pkg::TPC_SEL_B;
         end else begin
            d.cnt = q.cnt + 8'h01;
            d.pwm_out = 1'b0;
            d.sel = tpc_pkg::TPC_SEL_A;
         end
         // Latched value is taken on a match with the old high/duty value
         if (!q.mask && match && q.sel == tpc_pkg::TPC_SEL_B && q.pending && !wr_cmp_b) begin
            if (q.age == `TPC_DUTY_AGE_MIN) begin
               d.duty_act = q.duty_latch;
               d.pending = 1'b0;
            end
         end
      end
      // Carrier gating: start on a carrier rising edge, stop only once it is low
      if (q.carrier_mode) begin
         if (active_en && !q.carrier && d.carrier) begin
            d.pass = 1'b1;
         end else if (!active_en && !d.carrier) begin
            d.pass = 1'b0;
         end
      end
      // Pin follows the next state so it stays one flop behind its cause
      // Next mode decides the branch, so a mode write never leaks a PWM level
      if (!d.carrier_mode) begin
         d.pin = d.pwm_out ^ d.level_sel;
      end else if (!d.remote) begin
         d.pin = active_en;
      end else begin
         d.pin = d.pass && d.carrier;
      end
      // Read data answer in the cycle after the strobe; unmapped reads as zero
      if (RD_I) begin
         case (ADDR_I)
            `TPC_OFS_CTRL: begin
               d.rdata = {5'h00, q.level_sel, q.carrier_mode, q.running};
            end
            `TPC_OFS_CMP_A: begin
               d.rdata = q.cmp_a;
            end
            `TPC_OFS_CMP_B: begin
               d.rdata = q.duty_act;
            end
            `TPC_OFS_CARRIER: begin
               d.rdata = {5'h00, q.remote, q.staged, active_en};
            end
            `TPC_OFS_COUNT: begin
               d.rdata = q.cnt;
            end
            default: begin
               d.rdata = `TPC_RST_BYTE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state flops
   assign RDATA_O = q.rdata;
   assign TOUT_O = q.pin;
   assign IRQ_O = q.irq;

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   a_first_mask: assert property (
      (CNT_TICK_I && q.running && q.mask && !WR_I) |=> (q.cnt == $past(q.cnt) && !q.mask))
      else $error("first count clock was not swallowed");
   a_duty_hold: assert property (
      (wr_cmp_b && q.running) |=> (q.duty_act == $past(q.duty_act) && q.pending))
      else $error("running duty write took effect at once");
   a_duty_early: assert property (
      (wr_cmp_b && q.running) |=> ($stable(q.duty_act))[*4])
      else $error("latched duty moved in too early");
   a_cycle_match: assert property (
      (CNT_TICK_I && q.running && !q.mask && !q.carrier_mode && match
       && q.sel == tpc_pkg::TPC_SEL_A && !WR_I)
      |=> (q.cnt == 8'h00 && IRQ_O && q.pwm_out && TOUT_O == !q.level_sel))
      else $error("cycle match did not clear, set output and interrupt");
   a_duty_match: assert property (
      (CNT_TICK_I && q.running && !q.mask && !q.carrier_mode && match
       && q.sel == tpc_pkg::TPC_SEL_B && !WR_I)
      |=> (!IRQ_O && !q.pwm_out && q.cnt == $past(q.cnt) + 8'h01))
      else $error("duty match misbehaved");
   a_stop_quiet: assert property (
      (q.running && wr_ctrl && !WDATA_I[`TPC_CTRL_RUN]) |=> (!IRQ_O && !q.pwm_out && !q.carrier))
      else $error("stop left interrupt or output active");
   a_irq_width: assert property (
      (IRQ_O && CNT_TICK_I) |=> !IRQ_O)
      else $error("interrupt longer than one count clock");
   a_carrier_flip: assert property (
      (CNT_TICK_I && q.running && !q.mask && q.carrier_mode && match && !WR_I)
      |=> (q.carrier != $past(q.carrier) && q.cnt == 8'h00 && IRQ_O && q.sel != $past(q.sel)))
      else $error("carrier match did not flip, clear and swap");
   a_pin_low: assert property (
      (q.carrier_mode && q.remote && !q.pass) |-> !TOUT_O)
      else $error("carrier pin high while gated off");
   a_hold_high: assert property (
      (q.carrier_mode && q.remote && q.pass && q.carrier) |-> TOUT_O)
      else $error("carrier high pulse truncated");
   a_start_low: assert property (
      (q.running && q.carrier_mode && q.sel == tpc_pkg::TPC_SEL_A && q.mask) |-> !q.carrier)
      else $error("carrier not low after start");
   // Stop leaves the PWM pin at the level that the select bit calls inactive
   a_stop_pin: assert property (
      (q.running && wr_ctrl && !WDATA_I[`TPC_CTRL_RUN] && !q.carrier_mode)
      |=> (TOUT_O == q.level_sel))
      else $error("stop left the output pin active");
   a_mode_locked: assert property (
      (wr_ctrl && q.running) |=> $stable(q.carrier_mode))
      else $error("mode changed while running");
   // With remote output off the pin is a plain copy of the active enable
   a_remote_off: assert property (
      (q.carrier_mode && !q.remote) |-> (TOUT_O == $past(active_en)))
      else $error("remote-off pin does not follow active enable");
   a_pass_start: assert property (
      $rose(q.pass) |-> $rose(q.carrier))
      else $error("carrier gating opened away from a carrier rise");
   // Read data must not linger past its one answer cycle
   a_rdata_idle: assert property (
      !$past(RD_I) |-> (RDATA_O == 8'h00))
      else $error("read data present without a read strobe");

   c_pwm_cycle: cover property (q.running && !q.carrier_mode && IRQ_O);
   c_duty_move: cover property (q.pending ##1 !q.pending && q.running);
   c_carrier_out: cover property (q.carrier_mode && q.pass && TOUT_O);
   c_gate_sync: cover property ($rose(synced_pulse));
   c_slow_irq: cover property (IRQ_O && !CNT_TICK_I);
endmodule : tpc_timer

//--- tb/tpc_pin_load.sv
// Load model on the timer output pin: measures high width and period
`timescale 1ns/1ps
module tpc_pin_load (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic [15:0] hi_w_o,
   output logic [15:0] per_o
);
   logic prev_q;
   logic [15:0] rc_q;
   logic [15:0] hc_q;
   // Passive load: counts clocks between rises and while high, never drives back
   always @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
         rc_q <= 16'h0000;
         hc_q <= 16'h0000;
         hi_w_o <= 16'h0000;
         per_o <= 16'h0000;
      end else begin
         prev_q <= pin_i;
         rc_q <= (pin_i && !prev_q) ? 16'h0001 : rc_q + 16'h0001;
         if (pin_i && !prev_q) per_o <= rc_q;
         if (pin_i) hc_q <= prev_q ? hc_q + 16'h0001 : 16'h0001;
         if (!pin_i && prev_q) hi_w_o <= hc_q;
      end
   end
endmodule : tpc_pin_load

//--- tb/tpc_timer_tb_top.sv
// Register-level testbench for the PWM and carrier timer
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_timer_tb_top;
   logic CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic CNT_TICK_I = 1'b0;
   logic GATE_IRQ_I = 1'b0;
   logic [2:0] ADDR_I = 3'h0;
   logic [7:0] WDATA_I = 8'h00;
   logic WR_I = 1'b0;
   logic RD_I = 1'b0;
   logic [7:0] RDATA_O;
   logic TOUT_O;
   logic IRQ_O;
   logic [15:0] hi_w;
   logic [15:0] per;
   logic [7:0] rv;
   int error_cnt = 0;
   int cmp_count = 0;
   int n;
   logic half_rate = 1'b0;

   // 50 MHz clock
   always #10 CLK_I = ~CLK_I;

   // Count clock: a tick every cycle, or every second cycle at half rate
   always @(posedge CLK_I) begin
      CNT_TICK_I <= !RST_I && (!half_rate || !CNT_TICK_I);
   end

   tpc_timer u_dut (.CLK_I(CLK_I), .RST_I(RST_I), .CNT_TICK_I(CNT_TICK_I),
      .GATE_IRQ_I(GATE_IRQ_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
      .RD_I(RD_I), .RDATA_O(RDATA_O), .TOUT_O(TOUT_O), .IRQ_O(IRQ_O));
   tpc_pin_load u_load (.clk_i(CLK_I), .rst_i(RST_I), .pin_i(TOUT_O), .hi_w_o(hi_w),
      .per_o(per));

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One-cycle write strobe beside address and data
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample mid-cycle
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      @(negedge CLK_I);
      d = RDATA_O;
   endtask : rd

   // Counts cycles in which a level is high over a window
   task automatic cnt_high(input int cyc, input bit irq, output int c);
      c = 0;
      repeat (cyc) begin
         @(negedge CLK_I);
         if (irq ? (IRQ_O === 1'b1) : (TOUT_O === 1'b1)) c++;
      end
   endtask : cnt_high

   // Gate pulse held eight clocks: gate count clock is at most two times slower
   task automatic gate_pulse;
      @(posedge CLK_I);
      GATE_IRQ_I <= 1'b1;
      repeat (8) @(posedge CLK_I);
      GATE_IRQ_I <= 1'b0;
      repeat (12) @(posedge CLK_I);
   endtask : gate_pulse

   // Watchdog: the tests need well under 2000 cycles
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end

   initial begin
      repeat (16) @(posedge CLK_I);
      RST_I <= 1'b0;
      // Reset values, unmapped place included
      for (int a = 0; a < 6; a++) begin
         rd(a[2:0], rv);
         chk("reset reg", 16'h0000, {8'h00, rv});
      end
      $display("reset test done");
      // PWM with cycle 3 and duty 1, both set while stopped
      wr(`TPC_OFS_CMP_A, 8'h03);
      wr(`TPC_OFS_CMP_B, 8'h01);
      wr(`TPC_OFS_CTRL, 8'h01);
      cnt_high(4, 1'b0, n);
      chk("start pin", 16'h0000, n[15:0]);
      repeat (20) @(posedge CLK_I);
      @(negedge CLK_I);
      chk("pwm period", 16'h0004, per);
      chk("pwm width", 16'h0002, hi_w);
      cnt_high(40, 1'b1, n);
      chk("pwm irq", 16'h000A, n[15:0]);
      wr(`TPC_OFS_CMP_B, 8'h02);
      rd(`TPC_OFS_CMP_B, rv);
      chk("duty old", 16'h0001, {8'h00, rv});
      repeat (20) @(posedge CLK_I);
      rd(`TPC_OFS_CMP_B, rv);
      chk("duty new", 16'h0002, {8'h00, rv});
      chk("pwm width 2", 16'h0003, hi_w);
      wr(`TPC_OFS_CTRL, 8'h00);
      cnt_high(10, 1'b0, n);
      chk("stop pin", 16'h0000, n[15:0]);
      cnt_high(10, 1'b1, n);
      chk("stop irq", 16'h0000, n[15:0]);
      $display("pwm test done");
      // Carrier with low width 3 and high width 4, remote set before start
      wr(`TPC_OFS_CMP_A, 8'h02);
      wr(`TPC_OFS_CMP_B, 8'h03);
      wr(`TPC_OFS_CARRIER, 8'h06);
      wr(`TPC_OFS_CTRL, 8'h03);
      gate_pulse();
      rd(`TPC_OFS_CARRIER, rv);
      chk("active on", 16'h0007, {8'h00, rv});
      repeat (30) @(posedge CLK_I);
      @(negedge CLK_I);
      chk("car period", 16'h0007, per);
      chk("car high", 16'h0004, hi_w);
      cnt_high(28, 1'b1, n);
      chk("car irq", 16'h0008, n[15:0]);
      // Active bit ignores writes and waits for the gate transfer
      wr(`TPC_OFS_CARRIER, 8'h04);
      rd(`TPC_OFS_CARRIER, rv);
      chk("active ro", 16'h0005, {8'h00, rv});
      gate_pulse();
      repeat (30) @(posedge CLK_I);
      @(negedge CLK_I);
      chk("car off pin", 16'h0000, {15'h0000, TOUT_O});
      chk("last high", 16'h0004, hi_w);
      rd(`TPC_OFS_CARRIER, rv);
      chk("active off", 16'h0004, {8'h00, rv});
      // Remote off: pin follows the active enable as a level
      wr(`TPC_OFS_CARRIER, 8'h02);
      gate_pulse();
      cnt_high(10, 1'b0, n);
      chk("remote off hi", 16'h000A, n[15:0]);
      wr(`TPC_OFS_CARRIER, 8'h00);
      gate_pulse();
      cnt_high(10, 1'b0, n);
      chk("remote off lo", 16'h0000, n[15:0]);
      // Half-rate count clock: widths double in clocks, interrupt spans one tick
      @(posedge CLK_I);
      half_rate <= 1'b1;
      wr(`TPC_OFS_CARRIER, 8'h06);
      gate_pulse();
      repeat (40) @(posedge CLK_I);
      @(negedge CLK_I);
      chk("half period", 16'h000E, per);
      chk("half high", 16'h0008, hi_w);
      cnt_high(28, 1'b1, n);
      chk("half irq", 16'h0008, n[15:0]);
      // Stop while in carrier mode: mode bit is kept, pin and interrupt drop
      wr(`TPC_OFS_CTRL, 8'h00);
      rd(`TPC_OFS_CTRL, rv);
      chk("stop ctrl", 16'h0002, {8'h00, rv});
      cnt_high(10, 1'b0, n);
      chk("car stop pin", 16'h0000, n[15:0]);
      cnt_high(10, 1'b1, n);
      chk("car stop irq", 16'h0000, n[15:0]);
      $display("carrier test done");
      give_verdict();
   end
endmodule : tpc_timer_tb_top
